/* File: hw/crc_engine_flash_autorun.sv */
`timescale 1ns/1ps
module crc_engine_flash_autorun (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // Flash read port
   output logic flash_req_out,
   output logic [16:0] flash_addr_out,
   input wire logic flash_ack_in,
   input wire logic [7:0] flash_data_in,
   // CPU stall
   output logic cpu_stall_out
);
   // ==========================================================
   // State
   logic [31:0] result, next_result;
   logic [4:0] control, next_control;
   logic [7:0] autorun_ctl, next_autorun_ctl;
   logic [5:0] sector_count, next_sector_count;
   logic [7:0] bit_reverse, next_bit_reverse;
   logic [16:0] addr, next_addr;
   logic [16:0] last_addr, next_last_addr;
   logic [7:0] rdata, next_rdata;
   crc_engine_pkg::run_state_e state, next_state;

   logic [31:0] fold_in_crc, fold_out_crc;
   logic [7:0] fold_data;
   logic width16;
   logic [1:0] pointer;
   logic ctl_write;
   logic run_start;
   logic fold_now;
   logic run_last;

   assign width16 = control[crc_engine_pkg::width_sel_bit];
   assign pointer = control[1:0];
   // Control writes only land while the CPU runs
   assign ctl_write = reg_wr_in && state == crc_engine_pkg::run_idle
      && reg_addr_in == crc_engine_pkg::engine_control_addr;
   assign run_start = ctl_write
      && autorun_ctl[crc_engine_pkg::autorun_enable_bit];
   assign fold_now = (state == crc_engine_pkg::run_fold);
   assign run_last = fold_now && addr == last_addr;

   function automatic logic [7:0] mirror(input logic [7:0] b);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[7 - i] = b[i];
      end
      return r;
   endfunction

   // Bit 1 of the pointer is ignored in 16-bit mode
   function automatic logic [1:0] eff_ptr(input logic [1:0] p,
                                          input logic w16);
      return w16 ? {1'b0, p[0]} : p;
   endfunction

   crc_byte_fold u_fold (
      .crc_in(fold_in_crc),
      .data_in(fold_data),
      .width16_in(width16),
      .crc_out(fold_out_crc)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [1:0] ep;
      ep = eff_ptr(pointer, width16);
      next_result = result;
      next_control = control;
      next_autorun_ctl = autorun_ctl;
      next_sector_count = sector_count;
      next_bit_reverse = bit_reverse;
      fold_in_crc = result;
      fold_data = reg_wdata_in;
      next_rdata = 8'h00;

      // Reads, taken while the engine is not stalling the CPU
      if (reg_rd_in && state == crc_engine_pkg::run_idle) begin
         case (reg_addr_in)
            crc_engine_pkg::result_port_addr: begin
               next_rdata = result[ep*8 +: 8];
               next_control[1:0] = pointer + 2'b01;
            end
            crc_engine_pkg::engine_control_addr:
               next_rdata = {3'b000, control};
            crc_engine_pkg::byte_input_addr: next_rdata = 8'h00;
            crc_engine_pkg::bit_reverse_addr: next_rdata = bit_reverse;
            crc_engine_pkg::autorun_control_addr:
               next_rdata = autorun_ctl;
            crc_engine_pkg::sector_count_addr:
               next_rdata = {2'b00, sector_count};
            default: next_rdata = 8'h00;
         endcase
      end

      if (reg_wr_in && state == crc_engine_pkg::run_idle) begin
         case (reg_addr_in)
            crc_engine_pkg::result_port_addr: begin
               next_result[ep*8 +: 8] = reg_wdata_in;
               if (width16) begin
                  next_result[31:16] = 16'h0000;
               end
               next_control[1:0] = pointer + 2'b01;
            end
            crc_engine_pkg::engine_control_addr: begin
               next_control = {reg_wdata_in[4], 1'b0,
                               reg_wdata_in[2:0]};
               if (reg_wdata_in[crc_engine_pkg::preset_strobe_bit]) begin
                  next_result = reg_wdata_in[
                     crc_engine_pkg::preset_value_bit] ?
                     (reg_wdata_in[4] ? 32'h0000ffff : 32'hffffffff)
                     : 32'h00000000;
               end
               if (run_start) begin
                  next_autorun_ctl[
                     crc_engine_pkg::autorun_complete_bit] = 1'b0;
               end
            end
            crc_engine_pkg::byte_input_addr: begin
               next_result = fold_out_crc;
            end
            crc_engine_pkg::bit_reverse_addr:
               next_bit_reverse = mirror(reg_wdata_in);
            crc_engine_pkg::autorun_control_addr: begin
               next_autorun_ctl = {reg_wdata_in[7], 1'b1,
                                   reg_wdata_in[5:0]};
            end
            crc_engine_pkg::sector_count_addr:
               next_sector_count = reg_wdata_in[5:0];
            default: ;
         endcase
      end

      // Flash bytes fold in the cycle after their acknowledge
      if (fold_now) begin
         fold_data = flash_data_in;
         next_result = fold_out_crc;
         if (run_last) begin
            next_autorun_ctl[
               crc_engine_pkg::autorun_complete_bit] = 1'b1;
         end
      end
   end

   // ==========================================================
   // Run sequencer next values
   always_comb begin
      logic [16:0] start_addr;
      start_addr = {1'b0, autorun_ctl[5:0], 10'h000};
      next_addr = addr;
      next_last_addr = last_addr;
      next_state = state;
      case (state)
         crc_engine_pkg::run_idle: begin
            if (run_start) begin
               next_addr = start_addr;
               next_last_addr = 17'(start_addr
                  + ({sector_count, 10'h000} + 17'h003ff));
               next_state = crc_engine_pkg::run_request;
            end
         end
         crc_engine_pkg::run_request: begin
            if (flash_ack_in) begin
               next_state = crc_engine_pkg::run_fold;
            end
         end
         crc_engine_pkg::run_fold: begin
            if (run_last) begin
               next_state = crc_engine_pkg::run_idle;
            end else begin
               next_addr = 17'(addr + 17'h00001);
               next_state = crc_engine_pkg::run_request;
            end
         end
         default: next_state = crc_engine_pkg::run_idle;
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         result <= 32'h00000000;
         control <= crc_engine_pkg::engine_control_reset[4:0];
         autorun_ctl <= crc_engine_pkg::autorun_control_reset;
         sector_count <= crc_engine_pkg::sector_count_reset[5:0];
         bit_reverse <= crc_engine_pkg::bit_reverse_reset;
         rdata <= 8'h00;
      end else begin
         result <= next_result;
         control <= next_control;
         autorun_ctl <= next_autorun_ctl;
         sector_count <= next_sector_count;
         bit_reverse <= next_bit_reverse;
         rdata <= next_rdata;
      end
   end

   // ==========================================================
   // Run sequencer registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         addr <= 17'h00000;
         last_addr <= 17'h00000;
         state <= crc_engine_pkg::run_idle;
      end else begin
         addr <= next_addr;
         last_addr <= next_last_addr;
         state <= next_state;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_out = rdata;
   assign flash_req_out = (state == crc_engine_pkg::run_request);
   assign flash_addr_out = addr;
   // Stall stays up through the final fold
   assign cpu_stall_out = (state != crc_engine_pkg::run_idle);
endmodule

/* File: hw/crc_engine_pkg.sv */
// Contract
// - Each write to the byte input port folds that byte into the result.
// - Result port reads and writes target the byte chosen by the pointer.
// - With autorun enabled, any control register write starts a flash run.
// - Completion flag reads 0 during a run, 1 otherwise; resets to 1.
// - A flash run stalls the CPU, so firmware always sees completion set.
// - First-sector field sets the run start address at field times 1024.
// - Count field sets the run; last sector starts at (first+count)*1024.
// - Upper two bits of the sector count read zero, writes ignored.
// - Bit-reverse register reads back each written byte mirrored.
// - Width select 0 picks 32-bit 0x04c11db7, 1 picks 16-bit 0x1021.
// - Preset strobe loads all zeros or all ones per preset value select.
// - Pointer increments per result access; 16-bit mode aliases codes 2,3.
// - Result holds until preset, overwritten, or updated by input bytes.
package crc_engine_pkg;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] result_port_addr = 8'h91;
   localparam logic [7:0] engine_control_addr = 8'h92;
   localparam logic [7:0] byte_input_addr = 8'h93;
   localparam logic [7:0] bit_reverse_addr = 8'h95;
   localparam logic [7:0] autorun_control_addr = 8'h96;
   localparam logic [7:0] sector_count_addr = 8'h97;

   // ==========================================================
   // Field positions
   localparam int width_sel_bit = 4;
   localparam int preset_strobe_bit = 3;
   localparam int preset_value_bit = 2;
   localparam int autorun_enable_bit = 7;
   localparam int autorun_complete_bit = 6;

   // ==========================================================
   // Reset values and constants
   localparam logic [7:0] engine_control_reset = 8'h00;
   localparam logic [7:0] autorun_control_reset = 8'h40;
   localparam logic [7:0] sector_count_reset = 8'h00;
   localparam logic [7:0] bit_reverse_reset = 8'h00;
   localparam logic [31:0] poly32 = 32'h04c11db7;
   localparam logic [31:0] poly16 = 32'h00001021;
   localparam int sector_addr_bits = 10;
   localparam int flash_addr_width = 17;

   typedef enum logic [1:0] {
      run_idle = 2'b00,
      run_request = 2'b01,
      run_fold = 2'b10
   } run_state_e;

endpackage

/* File: hw/crc_byte_fold.sv */
`timescale 1ns/1ps
module crc_byte_fold (
   // Operands
   input wire logic [31:0] crc_in,
   input wire logic [7:0] data_in,
   input wire logic width16_in,
   // Result
   output logic [31:0] crc_out
);
   // ==========================================================
   // Eight serial steps, MSB first, unreflected
   always_comb begin
      logic [31:0] c;
      logic fb;
      c = crc_in;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (width16_in) begin
            fb = c[15] ^ data_in[i];
            c = {16'h0000, c[14:0], 1'b0};
            if (fb) begin
               c = c ^ crc_engine_pkg::poly16;
            end
         end else begin
            fb = c[31] ^ data_in[i];
            c = {c[30:0], 1'b0};
            if (fb) begin
               c = c ^ crc_engine_pkg::poly32;
            end
         end
      end
      crc_out = c;
   end
endmodule

/* File: sim/crc_engine_flash_autorun_chk.sv */
`timescale 1ns/1ps
module crc_engine_flash_autorun_chk (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   // Flash and stall
   input wire logic flash_req_out,
   input wire logic [16:0] flash_addr_out,
   input wire logic flash_ack_in,
   input wire logic cpu_stall_out
);
   // ==========
   // Shadow of run setup
   logic [6:0] auto, next_auto;
   logic [5:0] count, next_count;
   logic [16:0] taken, next_taken;
   logic ok;
   assign ok = reg_wr_in && !cpu_stall_out;
   always_comb begin
      next_auto = auto;
      next_count = count;
      next_taken = taken;
      if (ok && reg_addr_in == 8'h96)
         next_auto = {reg_wdata_in[7], reg_wdata_in[5:0]};
      if (ok && reg_addr_in == 8'h97)
         next_count = reg_wdata_in[5:0];
      if (flash_req_out && flash_ack_in)
         next_taken = flash_addr_out;
   end
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         auto <= 7'h00;
         count <= 6'h00;
         taken <= 17'h00000;
      end else begin
         auto <= next_auto;
         count <= next_count;
         taken <= next_taken;
      end
   end
   function automatic logic [7:0] rev8(logic [7:0] v);
      for (int i = 0; i < 8; i++)
         rev8[i] = v[7 - i];
   endfunction
   // ==========
   // Properties
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence flip_wr_s;
      ok && reg_addr_in == 8'h95;
   endsequence
   sequence flip_rd_s;
      reg_rd_in && reg_addr_in == 8'h95 && !cpu_stall_out;
   endsequence
   rdata_idle_a: assert property (!reg_rd_in |=>
      reg_rdata_out == 8'h00)
      else $error("read data not idle");
   rd_refused_a: assert property (reg_rd_in && cpu_stall_out |=>
      reg_rdata_out == 8'h00)
      else $error("read taken while stalled");
   flip_read_a: assert property (flip_wr_s ##2 flip_rd_s |=>
      reg_rdata_out == rev8($past(reg_wdata_in, 3)))
      else $error("flip read wrong");
   count_upper_a: assert property (reg_rd_in && reg_addr_in == 8'h97
      && !cpu_stall_out |=> reg_rdata_out[7:6] == 2'b00)
      else $error("count upper bits set");
   done_read_a: assert property (reg_rd_in && reg_addr_in == 8'h96
      && !cpu_stall_out |=> reg_rdata_out[6])
      else $error("done flag low");
   run_start_a: assert property (ok && reg_addr_in == 8'h92 && auto[6]
      |=> cpu_stall_out && flash_req_out)
      else $error("run not started");
   start_addr_a: assert property ($rose(cpu_stall_out) |->
      flash_addr_out == {1'b0, auto[5:0], 10'h000})
      else $error("bad start address");
   addr_step_a: assert property (cpu_stall_out &&
      $past(cpu_stall_out) && $changed(flash_addr_out) |->
      flash_addr_out == $past(flash_addr_out) + 17'h1)
      else $error("address not ascending");
   last_addr_a: assert property ($fell(cpu_stall_out) |->
      taken == {7'(auto[5:0]) + 7'(count), 10'h3ff})
      else $error("run ended at wrong address");
   req_in_run_a: assert property (flash_req_out |-> cpu_stall_out)
      else $error("request outside run");
endmodule
bind crc_engine_flash_autorun crc_engine_flash_autorun_chk chk (
   .sys_clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
   .reg_wdata_in, .reg_rdata_out, .flash_req_out, .flash_addr_out,
   .flash_ack_in, .cpu_stall_out);

/* File: sim/flash_model.sv */
`timescale 1ns/1ps
module flash_model (
   // Clock
   input wire logic sys_clk_in,
   // Flash read port
   input wire logic req_in,
   input wire logic [16:0] addr_in,
   output logic ack_out,
   output logic [7:0] data_out
);
   initial begin
      ack_out = 1'b0;
      data_out = 8'h5a;
   end
   // Data toggles outside its one valid cycle so stale bytes show up
   always @(posedge sys_clk_in) begin
      if (ack_out && req_in) begin
         ack_out <= 1'b0;
         data_out <= addr_in[7:0] ^ addr_in[16:9];
      end else begin
         ack_out <= req_in && ($urandom % 3 != 0);
         data_out <= ~data_out;
      end
   end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic [7:0] reg_rdata_out, flash_data_in, v, b;
   logic flash_req_out, flash_ack_in, cpu_stall_out;
   logic [16:0] flash_addr_out;
   logic [31:0] crc;
   int err_count = 0;
   int comparisons = 0;
   always #2.5 sys_clk_in = ~sys_clk_in;
   crc_engine_flash_autorun dut (.sys_clk_in, .rst_n_in, .reg_addr_in,
      .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .flash_req_out,
      .flash_addr_out, .flash_ack_in, .flash_data_in, .cpu_stall_out);
   flash_model fm (.sys_clk_in, .req_in(flash_req_out),
      .addr_in(flash_addr_out), .ack_out(flash_ack_in),
      .data_out(flash_data_in));
   function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] d,
                                        logic w);
      logic [31:0] p;
      p = w ? crc_engine_pkg::poly16 : crc_engine_pkg::poly32;
      c = c ^ ({24'h0, d} << (w ? 8 : 24));
      for (int i = 0; i < 8; i++)
         c = (w ? c[15] : c[31]) ? (c << 1) ^ p : c << 1;
      return w ? {16'h0, c[15:0]} : c;
   endfunction
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge sys_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge sys_clk_in);
      reg_wr_in = 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge sys_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge sys_clk_in);
      reg_rd_in = 1'b0;
      v = reg_rdata_out;
   endtask
   task automatic complete_run();
      $display("Comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      complete_run();
   end
   initial begin
      void'($urandom(27));
      repeat (10) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      // Downward so the pointer read comes before the result port read
      for (int i = 0; i < 7; i++) begin
         rd(8'h97 - 8'(i));
         check("reset", v, i == 1 ? 8'h40 : 8'h00);
      end
      for (int i = 0; i < 6; i++) begin
         b = i == 0 ? 8'hc0 : i == 1 ? 8'h05 : 8'($urandom);
         wr(8'h95, b);
         rd(8'h95);
         check("flip", v, {b[0],b[1],b[2],b[3],b[4],b[5],b[6],b[7]});
      end
      wr(8'h97, 8'hff);
      rd(8'h97);
      check("count", v, 8'h3f);
      for (int m = 0; m < 4; m++) begin
         wr(8'h92, {3'b000, m[1], 1'b1, m[0], 2'b00});
         crc = m[0] ? (m[1] ? 32'h0000ffff : 32'hffffffff) : 32'h0;
         for (int k = 0; k < 5; k++) begin
            b = 8'($urandom);
            wr(8'h93, b);
            crc = fold(crc, b, m[1]);
         end
         for (int k = 0; k < 5; k++) begin
            rd(8'h91);
            check("result", v, 8'(crc >> 8 * (k % (m[1] ? 2 : 4))));
         end
      end
      wr(8'h92, 8'h00);
      for (int k = 0; k < 4; k++) begin
         crc[8 * k +: 8] = 8'($urandom);
         wr(8'h91, crc[8 * k +: 8]);
      end
      wr(8'h93, 8'ha5);
      crc = fold(crc, 8'ha5, 1'b0);
      for (int k = 0; k < 4; k++) begin
         rd(8'h91);
         check("written", v, crc[8 * k +: 8]);
      end
      wr(8'h92, 8'h0c);
      wr(8'h96, 8'h82);
      wr(8'h97, 8'h01);
      wr(8'h92, 8'h00);
      // Accesses while stalled must be ignored
      rd(8'h96);
      check("stalled read", v, 8'h00);
      wr(8'h97, 8'h3f);
      wr(8'h92, 8'h0c);
      crc = 32'hffffffff;
      for (int a = 2048; a < 4096; a++)
         crc = fold(crc, 8'(a) ^ 8'(a >> 9), 1'b0);
      for (int t = 0; t < 20000 && cpu_stall_out !== 1'b0; t++)
         @(negedge sys_clk_in);
      check("stall end", {7'h00, cpu_stall_out}, 8'h00);
      rd(8'h96);
      check("done", v, 8'hc2);
      rd(8'h97);
      check("count kept", v, 8'h01);
      for (int k = 0; k < 4; k++) begin
         rd(8'h91);
         check("autorun", v, crc[8 * k +: 8]);
      end
      wr(8'h96, 8'h02);
      wr(8'h92, 8'h00);
      check("no run", {7'h00, cpu_stall_out}, 8'h00);
      complete_run();
   end
endmodule
